/* rtl/evp_core.sv */
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "evp_defs.svh"
module evp_core (
	input wire logic clk_sys_in,
	input wire logic arst_n_in,
	input wire logic instr_valid_in,
	input wire logic [31:0] instr_in,
	input wire logic oldest_in,
	input wire logic cp0_usable_in,
	input wire logic [`EVP_VP_IDX_W-1:0] issuer_vp_in,
	input wire logic dvp_in,
	input wire logic [`EVP_NUM_VP-1:0] sib_wait_in,
	input wire logic [`EVP_NUM_VP-1:0] sib_pause_in,
	input wire logic [`EVP_NUM_VP-1:0] sib_ll_clear_in,
	input wire logic [`EVP_NUM_VP-1:0] sib_pause_exit_in,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`EVP_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic busy_out,
	output logic retire_out,
	output logic exc_ri_out,
	output logic exc_cpu_out,
	output logic gpr_we_out,
	output logic [4:0] gpr_addr_out,
	output logic [31:0] gpr_data_out,
	output logic [`EVP_NUM_VP-1:0] sib_fetch_en_out,
	output logic [`EVP_NUM_VP-1:0] sib_irq_en_out
);
	evp_pkg::evp_state_t state_reg;
	logic [31:0] cw_reg;
	logic [1:0] cfg_reg;
	logic [15:0] count_reg;
	logic [4:0] dest_reg;
	logic en_pulse_reg;
	logic dis_pulse;
	logic [`EVP_NUM_VP-1:0] fetch_w;
	logic [`EVP_NUM_VP-1:0] irq_w;
	logic [`EVP_NUM_VP-1:0] ack_w;
	logic all_ack;
	logic is_evp;
	logic take;
	logic dis_flag;
	logic [4:0] dest_f;
	logic [31:0] rd_data;
	logic rd_err;

	// ---------------------------------------------
	// Decode
	// ---------------------------------------------
	assign dest_f = instr_in[`EVP_DEST_LO+4:`EVP_DEST_LO];
	assign is_evp = (instr_in[31:`EVP_MAJOR_LO] == `EVP_MAJOR_VAL) &&
		(instr_in[`EVP_ZERO_LO+4:`EVP_ZERO_LO] == 5'h00) &&
		(instr_in[`EVP_FUNC_LO+9:`EVP_FUNC_LO] == `EVP_FUNC_VAL) &&
		(instr_in[5:0] == `EVP_MINOR_VAL);
	// Only the oldest unretired instruction is taken, never a speculative one
	assign take = instr_valid_in && oldest_in && is_evp && (state_reg == evp_pkg::EVP_IDLE) &&
		!retire_out && !exc_ri_out && !exc_cpu_out;
	assign dis_flag = cw_reg[`EVP_DIS_BIT];
	assign all_ack = &ack_w;
	// A disable arriving mid-sequence is masked by the EVP_IDLE state check; the pipeline keeps it back
	assign dis_pulse = dvp_in && (state_reg == evp_pkg::EVP_IDLE) && !dis_flag;

	// ---------------------------------------------
	// Siblings
	// ---------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < `EVP_NUM_VP; gi = gi + 1) begin : g_sib
			evp_sib u_sib (
				.clk_sys_in(clk_sys_in),
				.arst_n_in(arst_n_in),
				.is_issuer_in(issuer_vp_in == `EVP_VP_IDX_W'(gi)),
				.dis_pulse_in(dis_pulse),
				.en_pulse_in(en_pulse_reg),
				.wait_in(sib_wait_in[gi]),
				.pause_in(sib_pause_in[gi]),
				.ll_clear_in(sib_ll_clear_in[gi]),
				.pause_exit_in(sib_pause_exit_in[gi]),
				.fetch_en_out(fetch_w[gi]),
				.irq_en_out(irq_w[gi]),
				.ack_out(ack_w[gi])
			);
		end
	endgenerate

	assign sib_fetch_en_out = fetch_w;
	assign sib_irq_en_out = irq_w;

	// ---------------------------------------------
	// Sequencer
	// ---------------------------------------------
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_reg <= evp_pkg::EVP_IDLE;
		end else begin
			case (state_reg)
				evp_pkg::EVP_IDLE: begin
					if (take && cfg_reg[`EVP_CFG_R6_BIT] && cp0_usable_in &&
						cfg_reg[`EVP_CFG_MT_BIT] && dis_flag) begin
						state_reg <= evp_pkg::EVP_WAIT_ACK;
					end
				end
				evp_pkg::EVP_WAIT_ACK: begin
					// The pulse lands in the siblings before the acks are judged
					if (!en_pulse_reg && all_ack) begin
						state_reg <= evp_pkg::EVP_FINISH;
					end
				end
				evp_pkg::EVP_FINISH: begin
					state_reg <= evp_pkg::EVP_IDLE;
				end
				default: begin
					state_reg <= evp_pkg::EVP_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			en_pulse_reg <= 1'b0;
		end else begin
			en_pulse_reg <= take && cfg_reg[`EVP_CFG_R6_BIT] && cp0_usable_in &&
				cfg_reg[`EVP_CFG_MT_BIT] && dis_flag;
		end
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			dest_reg <= 5'h00;
		end else if (take) begin
			dest_reg <= dest_f;
		end
	end

	// Control word: the flag falls only at the end of the wait for acks
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cw_reg <= `EVP_CW_RESET;
		end else if (state_reg == evp_pkg::EVP_FINISH) begin
			cw_reg[`EVP_DIS_BIT] <= 1'b0;
		end else if (dis_pulse) begin
			cw_reg[`EVP_DIS_BIT] <= 1'b1;
		end
	end

	// Register write uses the word as it stood before the flag was touched
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			gpr_we_out <= 1'b0;
			gpr_addr_out <= 5'h00;
			gpr_data_out <= 32'h00000000;
		end else begin
			gpr_we_out <= en_pulse_reg && (dest_reg != 5'h00);
			gpr_addr_out <= dest_reg;
			gpr_data_out <= cw_reg;
		end
	end

	// Outcome: reserved ahead of unusable, then the no-operation cases
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			exc_ri_out <= 1'b0;
			exc_cpu_out <= 1'b0;
			retire_out <= 1'b0;
		end else begin
			exc_ri_out <= take && !cfg_reg[`EVP_CFG_R6_BIT];
			exc_cpu_out <= take && cfg_reg[`EVP_CFG_R6_BIT] && !cp0_usable_in;
			retire_out <= (take && cfg_reg[`EVP_CFG_R6_BIT] && cp0_usable_in &&
				(!cfg_reg[`EVP_CFG_MT_BIT] || !dis_flag)) ||
				(state_reg == evp_pkg::EVP_FINISH);
		end
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			busy_out <= 1'b0;
		end else begin
			busy_out <= en_pulse_reg || (state_reg == evp_pkg::EVP_WAIT_ACK && !all_ack);
		end
	end

	// Power gating between disable and enable leaves sibling state undefined; no recovery here

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			count_reg <= 16'h0000;
		end else if (state_reg == evp_pkg::EVP_FINISH) begin
			count_reg <= count_reg + 16'h0001;
		end
	end

	// ---------------------------------------------
	// APB slave
	// ---------------------------------------------
	always_comb begin
		rd_data = 32'h00000000;
		rd_err = 1'b0;
		case (paddr)
			`EVP_OFF_CTRL_WORD: rd_data = cw_reg;
			`EVP_OFF_CONFIG: rd_data = {30'h00000000, cfg_reg};
			`EVP_OFF_STATUS: rd_data = {16'h0000, irq_w, fetch_w, 5'h00, busy_out,
				state_reg};
			`EVP_OFF_COUNT: rd_data = {16'h0000, count_reg};
			default: rd_err = 1'b1;
		endcase
	end

	// One wait state: pready rises in the second access cycle
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && rd_err;
			prdata <= (psel && penable && !pready && !pwrite) ? rd_data : 32'h00000000;
		end
	end

	// Config changes made while a sequence runs apply to the next instruction only
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cfg_reg <= `EVP_CFG_RESET;
		end else if (psel && penable && pready && pwrite && paddr == `EVP_OFF_CONFIG) begin
			cfg_reg <= pwdata[1:0];
		end
	end

	// ---------------------------------------------
	// Checks
	// ---------------------------------------------
	property p_fetch_resumed;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		$fell(dis_flag) |-> (&ack_w);
	endproperty
	a_fetch_resumed: assert property (p_fetch_resumed) else $error("flag fell before acks");

	property p_pulse_after_take;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		en_pulse_reg |-> $past(take) && $past(dis_flag) && $past(cfg_reg[`EVP_CFG_MT_BIT]);
	endproperty
	a_pulse_after_take: assert property (p_pulse_after_take) else $error("bad enable pulse");

	property p_siblings_on;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		en_pulse_reg && !(|sib_pause_in) ##1 1'b1 |-> (&ack_w) && (&fetch_w);
	endproperty
	a_siblings_on: assert property (p_siblings_on) else $error("sibling fetch not resumed");

	property p_gpr_copy;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		en_pulse_reg && dest_reg != 5'h00 |=> gpr_we_out && gpr_data_out[`EVP_DIS_BIT];
	endproperty
	a_gpr_copy: assert property (p_gpr_copy) else $error("old word not returned");

	property p_gpr_zero;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		gpr_we_out |-> gpr_addr_out != 5'h00;
	endproperty
	a_gpr_zero: assert property (p_gpr_zero) else $error("write to zero register");

	property p_oldest;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		(retire_out || exc_ri_out || exc_cpu_out) && $past(state_reg) == evp_pkg::EVP_IDLE
		|-> $past(oldest_in) && $past(instr_valid_in);
	endproperty
	a_oldest: assert property (p_oldest) else $error("acted while not oldest");

	property p_no_mt_nop;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		take && !cfg_reg[`EVP_CFG_MT_BIT] && cfg_reg[`EVP_CFG_R6_BIT] && cp0_usable_in
		|=> retire_out && !en_pulse_reg ##1 !gpr_we_out;
	endproperty
	a_no_mt_nop: assert property (p_no_mt_nop) else $error("no-thread case not a nop");

	property p_cpu_exc;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		take && cfg_reg[`EVP_CFG_R6_BIT] && !cp0_usable_in |=> exc_cpu_out && !retire_out;
	endproperty
	a_cpu_exc: assert property (p_cpu_exc) else $error("missing unusable exception");

	property p_ri_exc;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		take && !cfg_reg[`EVP_CFG_R6_BIT] |=> exc_ri_out && !exc_cpu_out && !en_pulse_reg;
	endproperty
	a_ri_exc: assert property (p_ri_exc) else $error("missing reserved exception");

	property p_decode;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		en_pulse_reg |-> $past(instr_in[5:0]) == `EVP_MINOR_VAL &&
			$past(instr_in[`EVP_FUNC_LO+9:`EVP_FUNC_LO]) == `EVP_FUNC_VAL;
	endproperty
	a_decode: assert property (p_decode) else $error("wrong encoding accepted");

	property p_irq_back;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		en_pulse_reg |=> (&irq_w);
	endproperty
	a_irq_back: assert property (p_irq_back) else $error("interrupts not restored");

	property p_retire_bound;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		$rose(state_reg == evp_pkg::EVP_FINISH) |=> retire_out && !dis_flag;
	endproperty
	a_retire_bound: assert property (p_retire_bound) else $error("finish did not retire");

	property p_busy_wait;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		en_pulse_reg |=> busy_out;
	endproperty
	a_busy_wait: assert property (p_busy_wait) else $error("busy missing while waiting");

	property p_flag_set;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		dis_pulse |=> dis_flag;
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("disable flag not set");

	property p_flag_nop;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		take && cfg_reg[`EVP_CFG_R6_BIT] && cp0_usable_in && !dis_flag
		|=> retire_out && !en_pulse_reg;
	endproperty
	a_flag_nop: assert property (p_flag_nop) else $error("clear flag case not a nop");

	// Issuer changes are ignored for one cycle while its own enable catches up
	property p_issuer_on;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		$stable(issuer_vp_in) |-> fetch_w[issuer_vp_in];
	endproperty
	a_issuer_on: assert property (p_issuer_on) else $error("issuer fetch stopped");

	property p_flag_falls;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		$fell(dis_flag) |-> $past(state_reg) == evp_pkg::EVP_FINISH;
	endproperty
	a_flag_falls: assert property (p_flag_falls) else $error("flag cleared outside finish");
endmodule
`default_nettype wire

/* rtl/evp_defs.svh */
// Function
// - When the enable takes effect, fetch resumes on every virtual processor except the issuer; a pausing one whose load-linked flag cleared stays stopped.
// - The siblings-disabled flag is cleared only after every other virtual processor is re-enabled.
// - The old control word is copied to the named destination register when that field is non-zero.
// - The enable acts only while the siblings-disabled flag is 1, otherwise it is a no-operation.
// - The enable never acts speculatively and waits until it is the oldest unretired instruction.
// - With the multithread-present field at 0 the instruction is a no-operation.
// - Without access to the system-control coprocessor a coprocessor-unusable exception is raised.
// - Before release 6 the encoding raises a reserved-instruction exception.
// - Siblings resume at once and fully restorably, as if the disable had never happened; here a pausing sibling whose load-linked flag cleared stays stopped.
// - After a state-destroying event between disable and enable the outcome need not be defined.
// - A sibling that was waiting at the disable ignores interrupts until the enable.
// - A sibling that was pausing stays stopped if its load-linked flag cleared before the enable.
// - The decoder matches major 000000, zero bits 20..16, function 0011100101 and minor 111100.
`ifndef EVP_DEFS_SVH
`define EVP_DEFS_SVH

`define EVP_NUM_VP 4
`define EVP_VP_IDX_W 2
`define EVP_MAJOR_LO 26
`define EVP_MAJOR_VAL 6'h00
`define EVP_DEST_LO 21
`define EVP_ZERO_LO 16
`define EVP_FUNC_LO 6
`define EVP_FUNC_VAL 10'h0E5
`define EVP_MINOR_VAL 6'h3C
`define EVP_DIS_BIT 0
`define EVP_CW_RESET 32'h00000000
`define EVP_ADDR_W 12
`define EVP_OFF_CTRL_WORD 12'h000
`define EVP_OFF_CONFIG 12'h004
`define EVP_OFF_STATUS 12'h008
`define EVP_OFF_COUNT 12'h00C
`define EVP_CFG_MT_BIT 0
`define EVP_CFG_R6_BIT 1
`define EVP_CFG_RESET 2'h3

`endif

/* rtl/evp_pkg.sv */
package evp_pkg;
	typedef enum logic [1:0] {
		EVP_IDLE,
		EVP_WAIT_ACK,
		EVP_FINISH
	} evp_state_t;
endpackage

/* rtl/evp_sib.sv */
`timescale 1ns/10ps
`default_nettype none
`include "evp_defs.svh"
module evp_sib (
	input wire logic clk_sys_in,
	input wire logic arst_n_in,
	input wire logic is_issuer_in,
	input wire logic dis_pulse_in,
	input wire logic en_pulse_in,
	input wire logic wait_in,
	input wire logic pause_in,
	input wire logic ll_clear_in,
	input wire logic pause_exit_in,
	output logic fetch_en_out,
	output logic irq_en_out,
	output logic ack_out
);
	logic fetch_reg;
	logic irq_reg;
	logic pause_hold_reg;
	logic ll_gone_reg;
	logic blocked_reg;

	// ---------------------------------------------
	// Sticky state captured at the disable event
	// ---------------------------------------------
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pause_hold_reg <= 1'b0;
		end else if (dis_pulse_in && !is_issuer_in) begin
			pause_hold_reg <= pause_in;
		end else if (en_pulse_in) begin
			pause_hold_reg <= 1'b0;
		end
	end

	// Set wins over the clear at the disable event
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ll_gone_reg <= 1'b0;
		end else if (ll_clear_in && (pause_hold_reg || (dis_pulse_in && pause_in))) begin
			ll_gone_reg <= 1'b1;
		end else if (dis_pulse_in || en_pulse_in) begin
			ll_gone_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			fetch_reg <= 1'b1;
			blocked_reg <= 1'b0;
		end else if (is_issuer_in) begin
			fetch_reg <= 1'b1;
			blocked_reg <= 1'b0;
		end else if (dis_pulse_in) begin
			fetch_reg <= 1'b0;
		end else if (en_pulse_in) begin
			fetch_reg <= !(pause_hold_reg && ll_gone_reg);
			blocked_reg <= pause_hold_reg && ll_gone_reg;
		end else if (blocked_reg && pause_exit_in) begin
			fetch_reg <= 1'b1;
			blocked_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			irq_reg <= 1'b1;
		end else if (dis_pulse_in && !is_issuer_in && wait_in) begin
			irq_reg <= 1'b0;
		end else if (en_pulse_in || is_issuer_in) begin
			irq_reg <= 1'b1;
		end
	end

	assign fetch_en_out = fetch_reg;
	assign irq_en_out = irq_reg;
	// A held pause sibling counts as re-enabled: its state is restored, fetch waits on it
	assign ack_out = fetch_reg || blocked_reg || is_issuer_in;
endmodule
`default_nettype wire

/* test/evp_sib_model.sv */
`timescale 1ns/10ps
`default_nettype none
`include "evp_defs.svh"
module evp_sib_model (
	input wire logic clk_sys_in,
	input wire logic arst_n_in,
	input wire logic [`EVP_NUM_VP-1:0] wait_cmd_in,
	input wire logic [`EVP_NUM_VP-1:0] pause_cmd_in,
	input wire logic [`EVP_NUM_VP-1:0] ll_drop_cmd_in,
	input wire logic [`EVP_NUM_VP-1:0] exit_cmd_in,
	output logic [`EVP_NUM_VP-1:0] wait_out,
	output logic [`EVP_NUM_VP-1:0] pause_out,
	output logic [`EVP_NUM_VP-1:0] ll_clear_out,
	output logic [`EVP_NUM_VP-1:0] pause_exit_out
);
	// ----------------------------------------
	// Sibling status, one cycle behind the commands
	// ----------------------------------------
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wait_out <= '0;
			pause_out <= '0;
			ll_clear_out <= '0;
			pause_exit_out <= '0;
		end else begin
			wait_out <= wait_cmd_in;
			pause_out <= pause_cmd_in;
			// Only a pausing sibling holds a load-linked flag that can drop
			ll_clear_out <= ll_drop_cmd_in & pause_cmd_in;
			pause_exit_out <= exit_cmd_in;
		end
	end
endmodule
`default_nettype wire

/* test/tb_vp_enable_instruction.sv */
`timescale 1ns/10ps
`default_nettype none
`include "evp_defs.svh"
module tb_vp_enable_instruction;
	localparam int NV = `EVP_NUM_VP;
	typedef struct packed {
		logic [1:0] cfg;
		logic cp0;
		logic dis;
		logic [1:0] vp;
		logic [4:0] rt;
		logic [3:0] res;
		logic [3:0] fetch;
		logic eff;
	} evp_tb_row_t;
	// Result field is {reserved, unusable, retire, register write}; eff marks a real enable
	evp_tb_row_t rows [7] = '{
		'{2'h3, 1'b1, 1'b0, 2'h0, 5'h05, 4'h2, 4'hF, 1'b0},
		'{2'h3, 1'b1, 1'b1, 2'h2, 5'h05, 4'h3, 4'hF, 1'b1},
		'{2'h3, 1'b1, 1'b1, 2'h0, 5'h00, 4'h2, 4'hF, 1'b1},
		'{2'h2, 1'b1, 1'b1, 2'h1, 5'h05, 4'h2, 4'h2, 1'b0},
		'{2'h1, 1'b0, 1'b0, 2'h1, 5'h05, 4'h8, 4'h2, 1'b0},
		'{2'h3, 1'b0, 1'b0, 2'h1, 5'h05, 4'h4, 4'h2, 1'b0},
		'{2'h3, 1'b1, 1'b0, 2'h1, 5'h09, 4'h3, 4'hF, 1'b1}};
	logic clk_sys_in = 1'b0, arst_n_in = 1'b0, instr_valid_in = 1'b0, oldest_in = 1'b0;
	logic cp0_usable_in = 1'b1, dvp_in = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] instr_in = '0, pwdata = '0, prdata, gpr_data_out, rd, gdat;
	logic [`EVP_VP_IDX_W-1:0] issuer_vp_in = '0;
	logic [`EVP_ADDR_W-1:0] paddr = '0;
	logic [NV-1:0] sib_wait_in, sib_pause_in, sib_ll_clear_in, sib_pause_exit_in;
	logic [NV-1:0] sib_fetch_en_out, sib_irq_en_out;
	logic [NV-1:0] wcmd = '0, pcmd = '0, lcmd = '0, xcmd = '0;
	logic pready, pslverr, busy_out, retire_out, exc_ri_out, exc_cpu_out, gpr_we_out, er, bsy;
	logic [4:0] gpr_addr_out, gadr;
	logic [3:0] res;
	int mismatches = 0, cmp_count = 0;

	always #4 clk_sys_in = ~clk_sys_in;

	evp_sib_model i_sib (.clk_sys_in, .arst_n_in, .wait_cmd_in(wcmd), .pause_cmd_in(pcmd),
		.ll_drop_cmd_in(lcmd), .exit_cmd_in(xcmd), .wait_out(sib_wait_in),
		.pause_out(sib_pause_in), .ll_clear_out(sib_ll_clear_in),
		.pause_exit_out(sib_pause_exit_in));
	evp_core i_dut (.clk_sys_in, .arst_n_in, .instr_valid_in, .instr_in, .oldest_in,
		.cp0_usable_in, .issuer_vp_in, .dvp_in, .sib_wait_in, .sib_pause_in, .sib_ll_clear_in,
		.sib_pause_exit_in, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .busy_out, .retire_out, .exc_ri_out, .exc_cpu_out, .gpr_we_out,
		.gpr_addr_out, .gpr_data_out, .sib_fetch_en_out, .sib_irq_en_out);

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic print_verdict;
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tmo;
		mismatches++;
		$display("unexpected at %0t: wait ran out", $time);
		print_verdict();
	endtask

	function automatic logic [31:0] enc(input logic [4:0] rt);
		return {6'h00, rt, 5'h00, 10'h0E5, 6'h3C};
	endfunction

	// Request stands until pready is sampled high at a rising edge, then it is released
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys_in);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys_in);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys_in);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) tmo();
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic dvp(input logic [1:0] vp);
		@(posedge clk_sys_in);
		issuer_vp_in <= vp;
		dvp_in <= 1'b1;
		@(posedge clk_sys_in);
		dvp_in <= 1'b0;
		@(posedge clk_sys_in);
	endtask

	task automatic quiet(input logic [31:0] w, input logic old);
		@(posedge clk_sys_in);
		instr_valid_in <= 1'b1;
		instr_in <= w;
		oldest_in <= old;
		repeat (4) begin
			@(posedge clk_sys_in);
			#1;
			chk(32'({retire_out, exc_ri_out, exc_cpu_out, gpr_we_out}), 32'h0);
		end
	endtask

	task automatic issue(input logic [4:0] rt);
		int n;
		@(posedge clk_sys_in);
		instr_valid_in <= 1'b1;
		instr_in <= enc(rt);
		oldest_in <= 1'b1;
		res = '0;
		gadr = '0;
		gdat = '0;
		bsy = 1'b0;
		n = 0;
		do begin
			@(posedge clk_sys_in);
			#1;
			n++;
			if (busy_out === 1'b1) bsy = 1'b1;
			if (gpr_we_out === 1'b1) begin
				res[0] = 1'b1;
				gadr = gpr_addr_out;
				gdat = gpr_data_out;
			end
		end while ((retire_out | exc_ri_out | exc_cpu_out) !== 1'b1 && n < 20);
		if (n >= 20) tmo();
		res[3:1] = {exc_ri_out, exc_cpu_out, retire_out};
		@(posedge clk_sys_in);
		instr_valid_in <= 1'b0;
		oldest_in <= 1'b0;
		@(posedge clk_sys_in);
		#1;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (6) @(posedge clk_sys_in);
		arst_n_in <= 1'b1;
		@(posedge clk_sys_in);
		#1;
		chk(32'(sib_fetch_en_out), 32'hF);
		chk(32'(sib_irq_en_out), 32'hF);
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 12'h004, 32'h0);
		chk(rd, 32'h3);
		for (int i = 0; i < 7; i++) begin
			if (rows[i].dis) dvp(rows[i].vp);
			apb(1'b1, 12'h004, {30'h0, rows[i].cfg});
			cp0_usable_in <= rows[i].cp0;
			issue(rows[i].rt);
			chk(32'(res), 32'(rows[i].res));
			chk(32'(sib_fetch_en_out), 32'(rows[i].fetch));
			if (res[0]) chk(32'(gadr), 32'(rows[i].rt));
			if (res[0]) chk(gdat, 32'h1);
			chk(32'(bsy), 32'(rows[i].eff));
			apb(1'b0, 12'h000, 32'h0);
			chk(rd, (rows[i].fetch == 4'hF) ? 32'h0 : 32'h1);
		end
		apb(1'b0, 12'h00C, 32'h0);
		chk(rd, 32'h3);
		apb(1'b1, 12'h000, 32'hFFFFFFFF);
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 12'h010, 32'h0);
		chk(32'(er), 32'h1);
		chk(rd, 32'h0);
		wcmd <= 4'h4;
		pcmd <= 4'h8;
		dvp(2'h0);
		chk(32'({sib_irq_en_out, sib_fetch_en_out}), 32'hB1);
		apb(1'b0, 12'h008, 32'h0);
		chk(rd, 32'h0000B100);
		quiet(enc(5'h05) | 32'h00010000, 1'b1);
		quiet(enc(5'h05), 1'b0);
		@(posedge clk_sys_in);
		lcmd <= 4'h8;
		@(posedge clk_sys_in);
		lcmd <= '0;
		issue(5'h07);
		chk(32'(res), 32'h3);
		chk(32'(gadr), 32'h7);
		chk(32'(bsy), 32'h1);
		chk(32'({sib_irq_en_out, sib_fetch_en_out}), 32'hF7);
		wcmd <= '0;
		pcmd <= '0;
		xcmd <= 4'h8;
		@(posedge clk_sys_in);
		xcmd <= '0;
		repeat (3) @(posedge clk_sys_in);
		#1;
		chk(32'(sib_fetch_en_out), 32'hF);
		apb(1'b0, 12'h00C, 32'h0);
		chk(rd, 32'h4);
		// Reset in mid-run with the siblings stopped
		dvp(2'h3);
		chk(32'(sib_fetch_en_out), 32'h8);
		arst_n_in <= 1'b0;
		repeat (6) @(posedge clk_sys_in);
		arst_n_in <= 1'b1;
		@(posedge clk_sys_in);
		#1;
		chk(32'({sib_irq_en_out, sib_fetch_en_out}), 32'hFF);
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 12'h00C, 32'h0);
		chk(rd, 32'h0);
		print_verdict();
	end
endmodule
`default_nettype wire
